// file: rtl/csmgmt_dev.sv
`timescale 1ns/10ps
`include "csmgmt_map.svh"
module csmgmt_dev
    import csmgmt_pkg::*;
#(
    parameter int PF_W = `CSMGMT_PF_W,
    parameter int VF_W = `CSMGMT_VF_W,
    parameter int NUM_PF = `CSMGMT_NUM_PF,
    parameter int VFS_PER_PF = `CSMGMT_VFS_PER_PF,
    parameter int REGS = `CSMGMT_REGS_PER_FN,
    parameter logic [`CSMGMT_DATA_W-1:0] RW_MASK = 32'h0000_FFFF
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // management port
    csmgmt_if.dev mif,
    // user side: live register view, error flag, busy flag
    input wire logic [`CSMGMT_DATA_W-1:0] ro_status_i,
    output logic bad_target_o,
    output logic busy_o
);
    localparam int FNS = NUM_PF * (VFS_PER_PF + 1);
    localparam int IDX_W = $clog2(REGS);
    localparam int FN_W = $clog2(FNS);

    // ==========================================================
    // register storage, one row per function
    logic [`CSMGMT_DATA_W-1:0] regs [FNS][REGS];
    csmgmt_state_t state;
    logic [1:0] lat_cnt;
    logic is_wr;
    logic [IDX_W-1:0] idx;
    logic [FN_W-1:0] fn;
    logic fn_ok;

    // ==========================================================
    // decode: VF rows follow each PF row
    always_comb
    begin
        idx = mif.addr[`CSMGMT_WORD_LSB +: IDX_W];
        fn_ok = (int'(mif.mgmt_phys_func_sel) < NUM_PF);
        if (mif.mgmt_virt_func_flag)
        begin
            fn_ok = fn_ok && (int'(mif.mgmt_virt_func_offset) < VFS_PER_PF);
            fn = FN_W'(int'(mif.mgmt_phys_func_sel) * (VFS_PER_PF + 1)
                + int'(mif.mgmt_virt_func_offset) + 1);
        end
        else
        begin
            fn = FN_W'(int'(mif.mgmt_phys_func_sel) * (VFS_PER_PF + 1));
        end
    end

    // ==========================================================
    // access sequencer; inputs held stable by requester until ack
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= CSMGMT_IDLE;
            lat_cnt <= 2'h0;
            is_wr <= 1'b0;
        end
        else
        begin
            unique case (state)
                CSMGMT_IDLE:
                    if (mif.rd_en || mif.wr_en)
                    begin
                        state <= CSMGMT_BUSY;
                        is_wr <= mif.wr_en;
                        lat_cnt <= 2'h0;
                    end
                CSMGMT_BUSY:
                    if (lat_cnt == 2'(`CSMGMT_ACC_LAT - 1))
                        state <= CSMGMT_DONE;
                    else
                        lat_cnt <= lat_cnt + 2'h1;
                CSMGMT_DONE:
                    state <= CSMGMT_IDLE;
                default:
                    state <= CSMGMT_IDLE;
            endcase
        end
    end

    // ==========================================================
    // storage update: only RW bits take write data
    always_ff @(posedge clk_i)
    begin
        if (state == CSMGMT_DONE && is_wr && fn_ok)
            regs[fn][idx] <= (regs[fn][idx] & ~RW_MASK) | (mif.wdata & RW_MASK);
    end

    // ==========================================================
    // answer outputs
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mif.ack <= 1'b0;
            mif.rdata <= 32'h0000_0000;
            bad_target_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            mif.ack <= (state == CSMGMT_DONE);
            busy_o <= (state != CSMGMT_IDLE) || mif.rd_en || mif.wr_en;
            if (state == CSMGMT_DONE)
                bad_target_o <= !fn_ok;
            if (state == CSMGMT_DONE && !is_wr && fn_ok)
                mif.rdata <= (regs[fn][idx] & RW_MASK) | (ro_status_i & ~RW_MASK);
            else
                mif.rdata <= 32'h0000_0000;
        end
    end
endmodule

// file: include/csmgmt_map.svh
// Operation
// - read data valid only during acknowledge
// - one-cycle acknowledge ends every access
// - byte address, low two bits ignored
// - function select names PF, parent for VF
// - VF access sets flag and offset
// - VF offset below VF count of PF
// - every register readable through the port
// - writes change only writable bits
// - intended for error header logging, else debug
`ifndef CSMGMT_MAP_SVH
`define CSMGMT_MAP_SVH
`define CSMGMT_ADDR_W 12
`define CSMGMT_DATA_W 32
`define CSMGMT_WORD_LSB 2
`define CSMGMT_PF_W 1
`define CSMGMT_VF_W 11
`define CSMGMT_NUM_PF 2
`define CSMGMT_VFS_PER_PF 4
`define CSMGMT_REGS_PER_FN 16
`define CSMGMT_ACC_LAT 2
`endif

// file: include/csmgmt_pkg.sv
package csmgmt_pkg;
    typedef enum logic [1:0] {CSMGMT_IDLE, CSMGMT_BUSY, CSMGMT_DONE} csmgmt_state_t;
    typedef enum logic [1:0] {CSMGMT_REQ_IDLE, CSMGMT_REQ_WAIT} csmgmt_req_state_t;
endpackage

// file: include/csmgmt_if.sv
`timescale 1ns/10ps
`include "csmgmt_map.svh"
interface csmgmt_if #(
    parameter int PF_W = `CSMGMT_PF_W,
    parameter int VF_W = `CSMGMT_VF_W
);
    logic rd_en;
    logic wr_en;
    logic [`CSMGMT_ADDR_W-1:0] addr;
    logic [`CSMGMT_DATA_W-1:0] wdata;
    logic [PF_W-1:0] mgmt_phys_func_sel;
    logic mgmt_virt_func_flag;
    logic [VF_W-1:0] mgmt_virt_func_offset;
    logic [`CSMGMT_DATA_W-1:0] rdata;
    logic ack;
    modport dev (
        input rd_en, wr_en, addr, wdata, mgmt_phys_func_sel, mgmt_virt_func_flag,
        input mgmt_virt_func_offset,
        output rdata, ack
    );
    modport req (
        output rd_en, wr_en, addr, wdata, mgmt_phys_func_sel, mgmt_virt_func_flag,
        output mgmt_virt_func_offset,
        input rdata, ack
    );
endinterface

// file: rtl/csmgmt_req.sv
`timescale 1ns/10ps
`include "csmgmt_map.svh"
module csmgmt_req
    import csmgmt_pkg::*;
#(
    parameter int PF_W = `CSMGMT_PF_W,
    parameter int VF_W = `CSMGMT_VF_W
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // user command; taken only when ready_o
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [`CSMGMT_ADDR_W-1:0] cmd_addr_i,
    input wire logic [`CSMGMT_DATA_W-1:0] cmd_wdata_i,
    input wire logic [PF_W-1:0] cmd_pf_i,
    input wire logic cmd_vf_i,
    input wire logic [VF_W-1:0] cmd_vf_offset_i,
    output logic ready_o,
    // user answer
    output logic done_o,
    output logic [`CSMGMT_DATA_W-1:0] rdata_o,
    // management port
    csmgmt_if.req mif
);
    csmgmt_req_state_t state;

    // ==========================================================
    // one access at a time; fields held until ack
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= CSMGMT_REQ_IDLE;
            ready_o <= 1'b1;
            mif.rd_en <= 1'b0;
            mif.wr_en <= 1'b0;
            mif.addr <= 12'h000;
            mif.wdata <= 32'h0000_0000;
            mif.mgmt_phys_func_sel <= '0;
            mif.mgmt_virt_func_flag <= 1'b0;
            mif.mgmt_virt_func_offset <= '0;
        end
        else
        begin
            mif.rd_en <= 1'b0;
            mif.wr_en <= 1'b0;
            unique case (state)
                CSMGMT_REQ_IDLE:
                    if (cmd_valid_i)
                    begin
                        state <= CSMGMT_REQ_WAIT;
                        ready_o <= 1'b0;
                        mif.rd_en <= !cmd_write_i;
                        mif.wr_en <= cmd_write_i;
                        mif.addr <= {cmd_addr_i[`CSMGMT_ADDR_W-1:`CSMGMT_WORD_LSB], 2'h0};
                        mif.wdata <= cmd_wdata_i;
                        mif.mgmt_phys_func_sel <= cmd_pf_i;
                        mif.mgmt_virt_func_flag <= cmd_vf_i;
                        mif.mgmt_virt_func_offset <= cmd_vf_i ? cmd_vf_offset_i : '0;
                    end
                CSMGMT_REQ_WAIT:
                    if (mif.ack)
                    begin
                        state <= CSMGMT_REQ_IDLE;
                        ready_o <= 1'b1;
                    end
                default:
                    state <= CSMGMT_REQ_IDLE;
            endcase
        end
    end

    // ==========================================================
    // capture answer on the ack cycle only
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            done_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
        end
        else
        begin
            done_o <= (state == CSMGMT_REQ_WAIT) && mif.ack;
            if (state == CSMGMT_REQ_WAIT && mif.ack)
                rdata_o <= mif.rdata;
        end
    end
endmodule

// file: test/csmgmt_props.sv
`timescale 1ns/10ps
module csmgmt_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // management port
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [0:0] mgmt_phys_func_sel,
    input wire logic mgmt_virt_func_flag,
    input wire logic [10:0] mgmt_virt_func_offset,
    input wire logic [31:0] rdata,
    input wire logic ack
);
    logic req;
    assign req = rd_en || wr_en;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ====================
    // port timing
    ack_latency_a:
        assert property (req |-> ##4 ack) else $error("ack not four cycles after start");
    ack_cause_a:
        assert property (ack |-> $past(req, 4) && !req) else $error("ack without start");
    ack_single_a:
        assert property (ack |=> !ack) else $error("ack longer than one cycle");
    rdata_idle_a:
        assert property (!ack |-> rdata == 32'h0) else $error("read data outside ack");
    start_pulse_a:
        assert property (req |=> !req [*4]) else $error("new start before ack");
    no_both_a:
        assert property (!(rd_en && wr_en)) else $error("read and write together");
    addr_low_a:
        assert property (req |-> addr[1:0] == 2'h0) else $error("low address bits set");
    // the offset and selector travel with the address, so one check covers them all
    hold_stable_a:
        assert property (req |=> ($stable({addr, wdata, mgmt_phys_func_sel}) &&
            $stable({mgmt_virt_func_flag, mgmt_virt_func_offset})) [*4])
            else $error("request changed before ack");
    cover property (ack && $past(wr_en, 4));
    cover property (ack && $past(rd_en, 4));
    cover property (rd_en && mgmt_virt_func_flag);
endmodule

// file: test/csmgmt_tb.sv
`timescale 1ns/10ps
module csmgmt_tb;
    // ====================
    // harness
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic cmd_write_i = 1'b0;
    logic [11:0] cmd_addr_i = 12'h000;
    logic [31:0] cmd_wdata_i = 32'h0;
    logic cmd_pf_i = 1'b0;
    logic cmd_vf_i = 1'b0;
    logic [10:0] cmd_vf_offset_i = 11'h000;
    logic [31:0] ro_status_i = 32'hDEAD0000;
    logic ready_o, done_o, bad_target_o, busy_o;
    logic [31:0] rdata_o;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 clk_i = ~clk_i;
    csmgmt_if mif ();
    csmgmt_dev u_csmgmt_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .mif(mif),
        .ro_status_i(ro_status_i), .bad_target_o(bad_target_o), .busy_o(busy_o));
    csmgmt_req u_csmgmt_req (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
        .cmd_pf_i(cmd_pf_i), .cmd_vf_i(cmd_vf_i), .cmd_vf_offset_i(cmd_vf_offset_i),
        .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .mif(mif));
    csmgmt_props u_csmgmt_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en(mif.rd_en),
        .wr_en(mif.wr_en), .addr(mif.addr), .wdata(mif.wdata),
        .mgmt_phys_func_sel(mif.mgmt_phys_func_sel),
        .mgmt_virt_func_flag(mif.mgmt_virt_func_flag),
        .mgmt_virt_func_offset(mif.mgmt_virt_func_offset), .rdata(mif.rdata), .ack(mif.ack));
    // ====================
    // tasks
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // done is counted from the taking edge so latency drift shows at once
    task automatic do_cmd(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [12:0] fn);
        int n;
        while (ready_o !== 1'b1)
            step();
        cmd_valid_i = 1'b1;
        {cmd_write_i, cmd_addr_i, cmd_wdata_i, cmd_pf_i, cmd_vf_i, cmd_vf_offset_i} = {wr, a, d, fn};
        step();
        cmd_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 20)
        begin
            if (n == 2)
                chk({30'h0, busy_o, ready_o}, 32'h2);
            step();
            n++;
        end
        chk(32'(n), 32'h5);
        chk({30'h0, busy_o, ready_o}, 32'h1);
    endtask
    task automatic t_rw();
        do_cmd(1'b1, 12'h00C, 32'hA5A51234, 13'h0000);
        do_cmd(1'b0, 12'h00F, 32'h0, 13'h0000);
        chk(rdata_o, 32'hDEAD1234);
        ro_status_i = 32'h5A5A0000;
        do_cmd(1'b0, 12'h00C, 32'h0, 13'h0000);
        chk(rdata_o, 32'h5A5A1234);
        $display("rw test done");
    endtask
    task automatic t_funcs();
        logic [12:0] fn [4] = '{13'h0000, 13'h1000, 13'h0800, 13'h1803};
        for (int k = 0; k < 4; k++)
            do_cmd(1'b1, 12'h020, 32'h7700 + 32'(k), fn[k]);
        for (int k = 0; k < 4; k++)
        begin
            do_cmd(1'b0, 12'h020, 32'h0, fn[k]);
            chk(rdata_o, {16'h5A5A, 16'h7700 + 16'(k)});
        end
        $display("function test done");
    endtask
    task automatic t_bad();
        do_cmd(1'b1, 12'h020, 32'hFFFF, 13'h0804);
        chk({31'h0, bad_target_o}, 32'h1);
        do_cmd(1'b0, 12'h020, 32'h0, 13'h0804);
        chk(rdata_o, 32'h0);
        do_cmd(1'b0, 12'h020, 32'h0, 13'h0800);
        chk(rdata_o, 32'h5A5A7702);
        chk({31'h0, bad_target_o}, 32'h0);
        $display("bad target test done");
    endtask
    // reset in mid access: the half-done write must never land
    task automatic t_reset();
        logic [6:0] seen;
        cmd_valid_i = 1'b1;
        {cmd_write_i, cmd_addr_i, cmd_wdata_i, cmd_pf_i, cmd_vf_i, cmd_vf_offset_i} =
            {1'b1, 12'h020, 32'h0000BEEF, 13'h0000};
        step();
        cmd_valid_i = 1'b0;
        step();
        rst_n_i = 1'b0;
        repeat (2)
            step();
        seen = {mif.ack, mif.rd_en, mif.wr_en, ready_o, done_o, busy_o, bad_target_o};
        chk({25'h0, seen}, 32'h08);
        chk(mif.rdata, 32'h0);
        rst_n_i = 1'b1;
        do_cmd(1'b0, 12'h020, 32'h0, 13'h0000);
        chk(rdata_o, 32'h5A5A7700);
        $display("reset test done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ====================
    // sequence
    initial
    begin
        repeat (12) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        t_rw();
        t_funcs();
        t_bad();
        t_reset();
        complete_run();
    end
    initial
    begin
        #20000;
        n_errors++;
        complete_run();
    end
endmodule
